// ===== include/time_tag_pkg.sv
// Purpose: shared constants and types for the time tag action block
// Assumes: 16-bit register words at word addresses
// Notes:   all offsets are word addresses on the register port

package time_tag_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned WORD_W    = 16;
	localparam int unsigned MON_W     = 48;
	localparam int unsigned CTL_W     = 32;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_MON_CONFIG  = 8'h29;
	localparam logic [7:0] ADDR_ACTION_CFG  = 8'h39;
	localparam logic [7:0] ADDR_MON_CNT_LO  = 8'h3A;
	localparam logic [7:0] ADDR_MON_CNT_MID = 8'h3B;
	localparam logic [7:0] ADDR_MON_CNT_HI  = 8'h3C;
	localparam logic [7:0] ADDR_MON_UTL_LO  = 8'h3D;
	localparam logic [7:0] ADDR_MON_UTL_MID = 8'h3E;
	localparam logic [7:0] ADDR_MON_UTL_HI  = 8'h3F;
	localparam logic [7:0] ADDR_CTL_CNT_LO  = 8'h43;
	localparam logic [7:0] ADDR_CTL_CNT_HI  = 8'h44;
	localparam logic [7:0] ADDR_CTL_UTL_LO  = 8'h45;
	localparam logic [7:0] ADDR_CTL_UTL_HI  = 8'h46;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int unsigned MON_ACT_HI_POS = 15;
	localparam int unsigned MON_ACT_LO_POS = 14;
	localparam int unsigned CTL_ACT_HI_POS = 13;
	localparam int unsigned CTL_ACT_LO_POS = 12;
	localparam int unsigned CTL_WIDE_POS   = 3;
	localparam int unsigned CFG_KEEP_W     = 8;
	localparam int unsigned MON_SEL_W      = 2;
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam logic [1:0]  MON_SEL_RESET  = 2'h0;

	// monitor select code that gives the 16-bit simple monitor
	localparam logic [1:0]  MON_SEL_SIMPLE16 = 2'h1;

	// ****************************************
	// action codes
	// ****************************************
	typedef enum logic [1:0] {
		ACT_NONE    = 2'h0,
		ACT_CLEAR   = 2'h1,
		ACT_LOAD    = 2'h2,
		ACT_CAPTURE = 2'h3
	} tag_action_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

endpackage

// ===== logic/tag_counter.sv
// Purpose: free-running time tag counter with clear and load
// Assumes: clear and load are single-cycle pulses, never both
// Notes:   in narrow mode only the low word counts, upper words are zeroed by each tick, load or clear

`timescale 1ns/1ps
`default_nettype none

module tag_counter #(
	parameter int unsigned WIDTH = 48
) (
	input  wire logic             clk_i,      // block clock
	input  wire logic             rst_n_i,    // synchronised reset, active low
	input  wire logic             tick_i,     // count enable pulse
	input  wire logic             wide_i,     // full width when high
	input  wire logic             clear_i,    // clear count to zero
	input  wire logic             load_i,     // load count from load_val_i
	input  wire logic [WIDTH-1:0] load_val_i, // value to load
	output logic      [WIDTH-1:0] count_o     // current count
);

	localparam int unsigned NW = time_tag_pkg::WORD_W;

	generate
		if (WIDTH <= NW || (WIDTH % NW) != 0) begin : g_bad_width
			$error("tag_counter width must be a multiple of the word above one word");
		end
	endgenerate

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	logic [WIDTH-1:0] narrow_mask;
	logic [WIDTH-1:0] inc_val;

	assign narrow_mask = wide_i ? {WIDTH{1'b1}} : {{(WIDTH-NW){1'b0}}, {NW{1'b1}}};
	assign inc_val     = (count_q + {{(WIDTH-1){1'b0}}, 1'b1}) & narrow_mask;

	// host actions override the tick so a load is never bumped on its own edge
	always_comb begin
		count_d = count_q;
		if (clear_i) begin
			count_d = '0;
		end else if (load_i) begin
			count_d = load_val_i & narrow_mask;
		end else if (tick_i) begin
			count_d = inc_val;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_o = count_q;

endmodule

`default_nettype wire

// ===== logic/time_tag_action.sv
// Purpose: host action logic for the monitor and controller time tag counters
// Assumes: single host on a plain register port, read data one cycle later
// Notes:   actions take effect on the edge that takes the configuration write
//
// Added by the designer: strobed register access and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module time_tag_action (
	input  wire logic                      sys_clk_i,   // 10 MHz block clock
	input  wire logic                      rst_n_i,     // async reset, active low
	input  wire time_tag_pkg::reg_req_t    reg_req_i,   // register port request
	output logic [time_tag_pkg::WORD_W-1:0] rdata_o,    // read data, cycle after read
	input  wire logic                      mon_tick_i,  // monitor count pulse
	input  wire logic                      ctl_tick_i,  // controller count pulse
	output logic                           mon_wide_o,  // monitor uses 48-bit count
	output logic                           mon_ch10_o   // chapter10 monitor selected
);

	localparam int unsigned W  = time_tag_pkg::WORD_W;
	localparam int unsigned MW = time_tag_pkg::MON_W;
	localparam int unsigned CW = time_tag_pkg::CTL_W;

	// ****************************************
	// reset release
	// ****************************************
	logic rst_sync1_q;
	logic rst_sync2_q;
	logic rst_n;

	// release waits two edges so no flop leaves reset on a runt edge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	assign rst_n = rst_sync2_q;

	// ****************************************
	// address decode
	// ****************************************
	wire wr_cfg     = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_ACTION_CFG);
	wire wr_mon_cfg = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_MON_CONFIG);
	wire wr_mu_lo   = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_MON_UTL_LO);
	wire wr_mu_mid  = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_MON_UTL_MID);
	wire wr_mu_hi   = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_MON_UTL_HI);
	wire wr_cu_lo   = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_CTL_UTL_LO);
	wire wr_cu_hi   = reg_req_i.wr && (reg_req_i.addr == time_tag_pkg::ADDR_CTL_UTL_HI);

	// ****************************************
	// configuration
	// ****************************************
	logic [time_tag_pkg::CFG_KEEP_W-1:0] cfg_q;
	logic [time_tag_pkg::MON_SEL_W-1:0]  mon_sel_q;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q     <= time_tag_pkg::CFG_RESET;
			mon_sel_q <= time_tag_pkg::MON_SEL_RESET;
		end else begin
			if (wr_cfg) begin
				cfg_q <= reg_req_i.wdata[time_tag_pkg::CFG_KEEP_W-1:0];
			end
			if (wr_mon_cfg) begin
				mon_sel_q <= reg_req_i.wdata[time_tag_pkg::MON_SEL_W-1:0];
			end
		end
	end

	// codes 00 and 10 give the chapter10 monitor, always wide
	wire mon_ch10 = !mon_sel_q[0];
	wire mon_wide = (mon_sel_q != time_tag_pkg::MON_SEL_SIMPLE16);
	wire ctl_wide = cfg_q[time_tag_pkg::CTL_WIDE_POS];

	assign mon_wide_o = mon_wide;
	assign mon_ch10_o = mon_ch10;

	// ****************************************
	// action decode
	// ****************************************
	// action codes are never stored, so they cannot linger or read back
	wire [1:0] mon_code = wr_cfg ? reg_req_i.wdata[time_tag_pkg::MON_ACT_HI_POS:
		time_tag_pkg::MON_ACT_LO_POS] : 2'h0;
	wire [1:0] ctl_code = wr_cfg ? reg_req_i.wdata[time_tag_pkg::CTL_ACT_HI_POS:
		time_tag_pkg::CTL_ACT_LO_POS] : 2'h0;

	wire mon_clear   = (mon_code == time_tag_pkg::ACT_CLEAR);
	wire mon_load    = (mon_code == time_tag_pkg::ACT_LOAD);
	wire mon_capture = (mon_code == time_tag_pkg::ACT_CAPTURE);
	wire ctl_clear   = (ctl_code == time_tag_pkg::ACT_CLEAR);
	wire ctl_load    = (ctl_code == time_tag_pkg::ACT_LOAD);
	wire ctl_capture = (ctl_code == time_tag_pkg::ACT_CAPTURE);

	// ****************************************
	// counters
	// ****************************************
	logic [MW-1:0] mon_util_q;
	logic [CW-1:0] ctl_util_q;
	logic [MW-1:0] mon_count;
	logic [CW-1:0] ctl_count;

	tag_counter #(
		.WIDTH (MW)
	) u_mon_counter (
		.clk_i      (sys_clk_i),
		.rst_n_i    (rst_n),
		.tick_i     (mon_tick_i),
		.wide_i     (mon_wide),
		.clear_i    (mon_clear),
		.load_i     (mon_load),
		.load_val_i (mon_util_q),
		.count_o    (mon_count)
	);

	tag_counter #(
		.WIDTH (CW)
	) u_ctl_counter (
		.clk_i      (sys_clk_i),
		.rst_n_i    (rst_n),
		.tick_i     (ctl_tick_i),
		.wide_i     (ctl_wide),
		.clear_i    (ctl_clear),
		.load_i     (ctl_load),
		.load_val_i (ctl_util_q),
		.count_o    (ctl_count)
	);

	// ****************************************
	// utility registers
	// ****************************************
	logic [MW-1:0] mon_util_d;
	logic [CW-1:0] ctl_util_d;

	// capture wins over a host write to the same word in that cycle
	always_comb begin
		mon_util_d = mon_util_q;
		if (wr_mu_lo) begin
			mon_util_d[W-1:0] = reg_req_i.wdata;
		end
		if (wr_mu_mid) begin
			mon_util_d[2*W-1:W] = reg_req_i.wdata;
		end
		if (wr_mu_hi) begin
			mon_util_d[3*W-1:2*W] = reg_req_i.wdata;
		end
		if (mon_capture) begin
			if (mon_wide) begin
				mon_util_d = mon_count;
			end else begin
				mon_util_d[W-1:0] = mon_count[W-1:0];
			end
		end
	end

	always_comb begin
		ctl_util_d = ctl_util_q;
		if (wr_cu_lo) begin
			ctl_util_d[W-1:0] = reg_req_i.wdata;
		end
		if (wr_cu_hi) begin
			ctl_util_d[CW-1:W] = reg_req_i.wdata;
		end
		if (ctl_capture) begin
			if (ctl_wide) begin
				ctl_util_d = ctl_count;
			end else begin
				ctl_util_d[W-1:0] = ctl_count[W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mon_util_q <= '0;
			ctl_util_q <= '0;
		end else begin
			mon_util_q <= mon_util_d;
			ctl_util_q <= ctl_util_d;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [W-1:0] rsel;
	logic [W-1:0] rdata_q;

	always_comb begin
		rsel = '0;
		case (reg_req_i.addr)
			time_tag_pkg::ADDR_ACTION_CFG:  rsel = {8'h00, cfg_q};
			time_tag_pkg::ADDR_MON_CONFIG:  rsel = {14'h0000, mon_sel_q};
			time_tag_pkg::ADDR_MON_CNT_LO:  rsel = mon_count[W-1:0];
			time_tag_pkg::ADDR_MON_CNT_MID: rsel = mon_count[2*W-1:W];
			time_tag_pkg::ADDR_MON_CNT_HI:  rsel = mon_count[3*W-1:2*W];
			time_tag_pkg::ADDR_MON_UTL_LO:  rsel = mon_util_q[W-1:0];
			time_tag_pkg::ADDR_MON_UTL_MID: rsel = mon_util_q[2*W-1:W];
			time_tag_pkg::ADDR_MON_UTL_HI:  rsel = mon_util_q[3*W-1:2*W];
			time_tag_pkg::ADDR_CTL_CNT_LO:  rsel = ctl_count[W-1:0];
			time_tag_pkg::ADDR_CTL_CNT_HI:  rsel = ctl_count[CW-1:W];
			time_tag_pkg::ADDR_CTL_UTL_LO:  rsel = ctl_util_q[W-1:0];
			time_tag_pkg::ADDR_CTL_UTL_HI:  rsel = ctl_util_q[CW-1:W];
			default:                        rsel = '0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (reg_req_i.rd) begin
			rdata_q <= rsel;
		end else begin
			rdata_q <= '0;
		end
	end

	assign rdata_o = rdata_q;

endmodule

`default_nettype wire

// ===== sim/tb.sv
// Purpose: directed testbench for time_tag_action
// Assumes: bench drives the register port and ticks itself
// Notes:   ticks are held low around captures so counts stay predictable

`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                   clk;
	logic                   rst_n;
	time_tag_pkg::reg_req_t req;
	logic [15:0]            rdata;
	logic                   mon_tick;
	logic                   ctl_tick;
	logic                   mon_wide;
	logic                   mon_ch10;
	int                     errors;
	int                     cmp_count;

	time_tag_action i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req), .rdata_o(rdata),
		.mon_tick_i(mon_tick), .ctl_tick_i(ctl_tick), .mon_wide_o(mon_wide),
		.mon_ch10_o(mon_ch10));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask

	// tasks start and end just after a rising edge; a write leaves its request on the port
	// until the next request or idle replaces it, so no signal is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
	endtask

	task automatic idle();
		req <= '0;
		@(posedge clk);
	endtask

	// read data are judged mid-cycle, while they stand
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		chk($sformatf("reg %h", a), exp, rdata);
		@(posedge clk);
	endtask

	task automatic pulse(input int n);
		mon_tick <= 1'b1;
		ctl_tick <= 1'b1;
		repeat (n) @(posedge clk);
		mon_tick <= 1'b0;
		ctl_tick <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk("wide", 16'h0001, {15'h0000, mon_wide});
		chk("ch10", 16'h0001, {15'h0000, mon_ch10});
		rc(8'h39, 16'h0000);
		rc(8'h29, 16'h0000);
		$display("t_reset done");
	endtask

	task automatic t_modes();
		logic [1:0] s;
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			wr(8'h29, {14'h0000, s});
			idle();
			chk("wide", {15'h0000, s != 2'h1}, {15'h0000, mon_wide});
			chk("ch10", {15'h0000, !s[0]}, {15'h0000, mon_ch10});
		end
		$display("t_modes done");
	endtask

	task automatic t_cfg();
		wr(8'h39, 16'hff5c);
		rc(8'h39, 16'h005c);
		wr(8'h20, 16'hbeef);
		rc(8'h20, 16'h0000);
		wr(8'h3A, 16'h1234);
		rc(8'h3A, 16'h0000);
		$display("t_cfg done");
	endtask

	task automatic t_mon48();
		wr(8'h29, 16'h0003);
		wr(8'h3F, 16'h1234);
		wr(8'h3E, 16'h5678);
		wr(8'h3D, 16'hfffe);
		wr(8'h39, 16'h805c);
		rc(8'h3C, 16'h1234);
		rc(8'h3B, 16'h5678);
		rc(8'h3A, 16'hfffe);
		pulse(3);
		wr(8'h39, 16'hc05c);
		rc(8'h3A, 16'h0001);
		rc(8'h3D, 16'h0001);
		rc(8'h3E, 16'h5679);
		rc(8'h3F, 16'h1234);
		wr(8'h39, 16'h405c);
		rc(8'h3A, 16'h0000);
		rc(8'h3B, 16'h0000);
		rc(8'h3C, 16'h0000);
		$display("t_mon48 done");
	endtask

	task automatic t_mon16();
		wr(8'h29, 16'h0001);
		wr(8'h3D, 16'hfffe);
		wr(8'h39, 16'h805c);
		idle();
		pulse(3);
		rc(8'h3A, 16'h0001);
		rc(8'h3B, 16'h0000);
		wr(8'h39, 16'hc05c);
		rc(8'h3D, 16'h0001);
		rc(8'h3E, 16'h5679);
		$display("t_mon16 done");
	endtask

	task automatic t_ctl();
		wr(8'h45, 16'hffff);
		wr(8'h46, 16'h0001);
		wr(8'h39, 16'h205c);
		rc(8'h44, 16'h0001);
		rc(8'h43, 16'hffff);
		pulse(1);
		rc(8'h43, 16'h0000);
		rc(8'h44, 16'h0002);
		wr(8'h39, 16'h105c);
		rc(8'h43, 16'h0000);
		rc(8'h44, 16'h0000);
		rc(8'h39, 16'h005c);
		$display("t_ctl done");
	endtask

	// ****************************************
	// clock, reset, sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// the whole sequence needs about 110 cycles; 2000 leaves ample margin
	initial begin
		#(100 * 2000);
		errors++;
		print_verdict();
	end

	initial begin
		errors = 0;
		cmp_count = 0;
		req = '0;
		mon_tick = 1'b0;
		ctl_tick = 1'b0;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_modes();
		t_cfg();
		t_mon48();
		t_mon16();
		t_ctl();
		print_verdict();
	end
endmodule

`default_nettype wire

// ===== sim/time_tag_action_checker.sv
// Purpose: port level assertions for time_tag_action
// Assumes: one clock domain, requests only after the internal reset lifts
// Notes:   bound to every instance of the top module

`timescale 1ns/1ps
`default_nettype none

module time_tag_action_checker (
	input  wire logic                            sys_clk_i,  // block clock
	input  wire logic                            rst_n_i,    // reset, active low
	input  wire time_tag_pkg::reg_req_t          reg_req_i,  // register request
	input  wire logic [time_tag_pkg::WORD_W-1:0] rdata_o,    // read data
	input  wire logic                            mon_tick_i, // monitor tick
	input  wire logic                            ctl_tick_i, // controller tick
	input  wire logic                            mon_wide_o, // wide monitor count
	input  wire logic                            mon_ch10_o  // chapter10 monitor
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	wire logic wr_sel = reg_req_i.wr && reg_req_i.addr == 8'h29;
	wire logic wr_act = reg_req_i.wr && reg_req_i.addr == 8'h39;

	function automatic logic rd_at(input logic [7:0] a);
		return reg_req_i.rd && reg_req_i.addr == a;
	endfunction

	// ****************************************
	// properties
	// ****************************************
	property p_rdata_idle;
		!$past(reg_req_i.rd) |-> rdata_o == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	property p_narrow;
		wr_sel && reg_req_i.wdata[1:0] == 2'h1 |=> !mon_wide_o;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow select not taken");
	property p_wide;
		wr_sel && reg_req_i.wdata[1:0] != 2'h1 |=> mon_wide_o;
	endproperty
	a_wide: assert property (p_wide) else $error("wide select not taken");
	property p_ch10;
		wr_sel |=> mon_ch10_o == !$past(reg_req_i.wdata[0]);
	endproperty
	a_ch10: assert property (p_ch10) else $error("monitor kind wrong");
	property p_cfg_hi;
		rd_at(8'h39) |=> rdata_o[15:8] == 8'h00;
	endproperty
	a_cfg_hi: assert property (p_cfg_hi) else $error("action bits read nonzero");
	property p_mon_clear;
		wr_act && reg_req_i.wdata[15:14] == 2'h1 ##1 rd_at(8'h3A) |=> rdata_o == 16'h0000;
	endproperty
	a_mon_clear: assert property (p_mon_clear) else $error("monitor clear failed");
	property p_ctl_clear;
		wr_act && reg_req_i.wdata[13:12] == 2'h1 ##1 rd_at(8'h43) |=> rdata_o == 16'h0000;
	endproperty
	a_ctl_clear: assert property (p_ctl_clear) else $error("controller clear failed");
	property p_capture;
		wr_act && reg_req_i.wdata[15:14] == 2'h3 && !mon_tick_i ##1 rd_at(8'h3A) && !mon_tick_i
			##2 rd_at(8'h3D) |=> rdata_o == $past(rdata_o, 2);
	endproperty
	a_capture: assert property (p_capture) else $error("capture differs from count");
endmodule

bind time_tag_action time_tag_action_checker i_chk (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .rdata_o(rdata_o),
	.mon_tick_i(mon_tick_i), .ctl_tick_i(ctl_tick_i), .mon_wide_o(mon_wide_o),
	.mon_ch10_o(mon_ch10_o)
);

`default_nettype wire
